/* gfp_pkg.sv */
// Purpose: shared constants for the gauge flag and power-mode block
// Assumes: apb, 32-bit data, one register per aligned word
// Notes:   temperatures signed 8-bit, currents signed 16-bit, voltages 16-bit
package gfp_pkg;
  // -----
  // register byte addresses
  // -----
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_OTLIM = 8'h04;
  localparam logic [7:0] A_INH   = 8'h08;
  localparam logic [7:0] A_DLY   = 8'h0c;
  localparam logic [7:0] A_CUR   = 8'h10;
  localparam logic [7:0] A_IDLE  = 8'h14;
  localparam logic [7:0] A_TAPER = 8'h18;
  localparam logic [7:0] A_VOLT  = 8'h1c;
  localparam logic [7:0] A_LVL   = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  // -----
  // control word fields
  // -----
  localparam int B_TSEL   = 0;
  localparam int B_SYNC   = 1;
  localparam int B_LIDLE  = 2;
  localparam int B_RLO    = 3;
  localparam int B_RHI    = 4;
  localparam int B_SWIRE  = 5;
  localparam int B_DREQ   = 6;
  localparam int B_DIDLE  = 7;
  localparam logic [7:0] CFG_RST = 8'h01;
  // -----
  // other constants
  // -----
  localparam logic [7:0]  LVL_OFF    = 8'hff;  // -1 disables a threshold
  localparam logic [15:0] DCAP_MIN   = 16'h0019; // 0.25 mAh in 10 uAh units
  localparam logic [1:0]  TAPER_WINS = 2'h2;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STRETCH_MAX_NS = 4000000;
  localparam int STRETCH_CYC    = STRETCH_MAX_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_CAL, ST_LIGHT, ST_DEEP, ST_DORMANT
  } gfp_state_t;
endpackage

/* gfp_top.sv */
// Purpose: status flags and power-state sequencing of a battery gauge
// Assumes: measurement inputs synchronous to pclk, meas_tick one-cycle pulse
// Notes:   delays and wait times count meas_tick pulses
//
// Local design decisions: register access over APB and the placing of the registers.

// Overview of operation
// RQ1 - external thermistor unless source bit cleared
// RQ2 - charge overheat after delay, clear at recovery
// RQ3 - discharge overheat after delay, clear at recovery
// RQ4 - zero discharge delay disables discharge overheat
// RQ5 - terminate after two qualifying taper windows
// RQ6 - termination clears charge flag, optional capacity sync
// RQ7 - alarm level -1 alarms on taper
// RQ8 - full level -1 waits for taper
// RQ9 - charge inhibit with hysteresis band
// RQ10 - normal state measures and decides transitions
// RQ11 - light idle after autocalibration when allowed
// RQ12 - idle states may stretch bus 4 ms
// RQ13 - leave light idle on current or wake
// RQ14 - deep idle by timer or host command
// RQ15 - bus wakes deep idle, flag per wait
// RQ16 - leave deep idle on current or wake
// RQ17 - dormant needs relaxed voltage and low current
// RQ18 - only own-address traffic wakes dormant
// RQ19 - dormant wake clears dormant request bit
// RQ20 - shutdown pin only for low-voltage dormant
// RQ21 - dormant disabled on single-wire link
// RQ22 - both range bits zero disable wake
// RQ23 - overheat timers restart when qualification drops
module gfp_top import gfp_pkg::*; #(
  parameter int STRETCH_CYCLES = STRETCH_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [7:0]  ext_temp,
  input  wire logic signed [7:0]  int_temp,
  input  wire logic signed [15:0] avg_current,
  input  wire logic [15:0]        cell_voltage,
  input  wire logic               meas_tick,
  input  wire logic               window_tick,
  input  wire logic [15:0]        window_dcap,
  input  wire logic               sense_over,
  input  wire logic               ocv_valid,
  input  wire logic               autocal_done,
  input  wire logic               tca_hit,
  input  wire logic               fc_hit,
  input  wire logic               bus_activity,
  input  wire logic               bus_addr_match,
  input  wire logic               host_ready,
  output logic                    charge_overheat_flag,
  output logic                    discharge_overheat_flag,
  output logic                    charge_flag,
  output logic                    full_charge_flag,
  output logic                    termination_alarm,
  output logic                    charge_inhibit_flag,
  output logic                    rm_load_fcc,
  output logic                    autocal_start,
  output logic                    measure_en,
  output logic                    bus_hold_low,
  output logic                    shutdown_enable_pin,
  output gfp_state_t              power_state
);
  initial begin
    if (STRETCH_CYCLES < 1 || STRETCH_CYCLES >= (1 << 20))
      $error("STRETCH_CYCLES out of range");
  end

  // -----
  // apb slave
  // -----
  logic [7:0]  cfg_r;
  logic [31:0] otlim_r, inh_r, dly_r, cur_r, idle_r, taper_r, volt_r, lvl_r;
  logic [31:0] stat_w;
  logic        wr_en, mapped;
  logic        deep_idle_r, dorm_wake;

  assign wr_en  = psel & penable & pready & pwrite;
  assign mapped = (paddr <= A_STAT) && (paddr[1:0] == 2'h0);

  // one wait state keeps prdata a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0;
      if (psel & penable & ~pready & ~pwrite) begin
        unique case (paddr)
          A_CFG:   prdata <= {24'h0, cfg_r[7:1], cfg_r[B_TSEL]};
          A_OTLIM: prdata <= otlim_r;
          A_INH:   prdata <= inh_r;
          A_DLY:   prdata <= dly_r;
          A_CUR:   prdata <= cur_r;
          A_IDLE:  prdata <= idle_r;
          A_TAPER: prdata <= taper_r;
          A_VOLT:  prdata <= volt_r;
          A_LVL:   prdata <= lvl_r;
          A_STAT:  prdata <= stat_w;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= CFG_RST;
      otlim_r <= 32'h0;
      inh_r   <= 32'h0;
      dly_r   <= 32'h0;
      cur_r   <= 32'h0;
      idle_r  <= 32'h0;
      taper_r <= 32'h0;
      volt_r  <= 32'h0;
      lvl_r   <= 32'h0;
    end else begin
      if (wr_en) begin
        unique case (paddr)
          A_CFG:   cfg_r   <= pwdata[7:0];
          A_OTLIM: otlim_r <= pwdata;
          A_INH:   inh_r   <= pwdata;
          A_DLY:   dly_r   <= pwdata;
          A_CUR:   cur_r   <= pwdata;
          A_IDLE:  idle_r  <= pwdata;
          A_TAPER: taper_r <= pwdata;
          A_VOLT:  volt_r  <= pwdata;
          A_LVL:   lvl_r   <= pwdata;
          default: ;
        endcase
      end
      cfg_r[B_DIDLE] <= deep_idle_r;
      // hardware clear loses to a host write of one
      if (dorm_wake && !(wr_en && paddr == A_CFG && pwdata[B_DREQ]))
        cfg_r[B_DREQ] <= 1'b0; // [RQ19]
    end
  end

  // -----
  // temperature and overheat
  // -----
  function automatic logic [15:0] step_timer(input logic qual, input logic [15:0] cnt,
                                             input logic [15:0] lim, input logic tick);
    if (!qual) step_timer = 16'h0;
    else if (tick && cnt < lim) step_timer = cnt + 16'h1;
    else step_timer = cnt;
  endfunction

  logic signed [7:0]  temp;
  logic signed [15:0] chg_thr, dsg_thr;
  logic [15:0] chg_cnt_r, dsg_cnt_r;
  logic        chg_q, dsg_q;

  assign temp    = cfg_r[B_TSEL] ? ext_temp : int_temp; // [RQ1]
  assign chg_thr = $signed(cur_r[15:0]);
  assign dsg_thr = -$signed(cur_r[31:16]);
  assign chg_q   = temp >= $signed(otlim_r[7:0]) && avg_current >= chg_thr;
  assign dsg_q   = temp >= $signed(otlim_r[23:16]) && avg_current <= dsg_thr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_cnt_r            <= 16'h0;
      dsg_cnt_r            <= 16'h0;
      charge_overheat_flag    <= 1'b0;
      discharge_overheat_flag <= 1'b0;
    end else begin
      chg_cnt_r <= step_timer(chg_q, chg_cnt_r, dly_r[15:0], meas_tick); // [RQ23]
      dsg_cnt_r <= step_timer(dsg_q, dsg_cnt_r, dly_r[31:16], meas_tick); // [RQ23]
      if (dly_r[15:0] == 16'h0)
        charge_overheat_flag <= 1'b0;
      else if (chg_q && chg_cnt_r == dly_r[15:0])
        charge_overheat_flag <= 1'b1; // [RQ2]
      else if (temp <= $signed(otlim_r[15:8]))
        charge_overheat_flag <= 1'b0; // [RQ2]
      if (dly_r[31:16] == 16'h0)
        discharge_overheat_flag <= 1'b0; // [RQ4]
      else if (dsg_q && dsg_cnt_r == dly_r[31:16])
        discharge_overheat_flag <= 1'b1; // [RQ3]
      else if (temp <= $signed(otlim_r[31:24]))
        discharge_overheat_flag <= 1'b0; // [RQ3]
    end
  end

  // -----
  // charge inhibit, widened to avoid wrap at the band edges
  // -----
  logic signed [8:0] inh_lo, inh_hi, inh_hys;
  assign inh_lo  = 9'($signed(inh_r[7:0]));
  assign inh_hi  = 9'($signed(inh_r[15:8]));
  assign inh_hys = 9'($signed(inh_r[23:16]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) charge_inhibit_flag <= 1'b0;
    else if (9'(temp) < inh_lo || 9'(temp) > inh_hi)
      charge_inhibit_flag <= 1'b1; // [RQ9]
    else if (9'(temp) >= inh_lo + inh_hys && 9'(temp) <= inh_hi - inh_hys)
      charge_inhibit_flag <= 1'b0; // [RQ9]
  end

  // -----
  // taper termination
  // -----
  logic [1:0] taper_cnt_r;
  logic       win_ok, term;
  assign win_ok = avg_current < $signed(taper_r[15:0]) && window_dcap > DCAP_MIN
                  && cell_voltage > volt_r[15:0] - taper_r[31:16];
  assign term   = window_tick && win_ok && taper_cnt_r == TAPER_WINS - 2'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taper_cnt_r       <= 2'h0;
      charge_flag       <= 1'b0;
      rm_load_fcc       <= 1'b0;
      termination_alarm <= 1'b0;
      full_charge_flag  <= 1'b0;
    end else begin
      if (window_tick)
        taper_cnt_r <= win_ok ? ((taper_cnt_r == TAPER_WINS) ? TAPER_WINS
                                 : taper_cnt_r + 2'h1) : 2'h0; // [RQ5]
      rm_load_fcc <= term && cfg_r[B_SYNC]; // [RQ6]
      if (term) charge_flag <= 1'b0; // [RQ6]
      else if (avg_current >= chg_thr && taper_cnt_r == 2'h0) charge_flag <= 1'b1;
      if (lvl_r[23:16] == LVL_OFF) begin
        if (term) termination_alarm <= 1'b1; // [RQ7]
        else if (avg_current < 16'sh0) termination_alarm <= 1'b0;
      end else termination_alarm <= tca_hit;
      if (lvl_r[31:24] == LVL_OFF) begin
        if (term) full_charge_flag <= 1'b1; // [RQ8]
        else if (avg_current < 16'sh0) full_charge_flag <= 1'b0;
      end else full_charge_flag <= fc_hit;
    end
  end

  // -----
  // power state machine
  // -----
  gfp_state_t  state_r;
  logic [15:0] wait_cnt_r;
  logic        wake_hit, idle_exit, dorm_ok, low_v, by_low_v_r;
  logic [19:0] hold_cnt_r;
  logic [15:0] abs_cur;

  assign abs_cur   = avg_current[15] ? 16'(-avg_current) : avg_current;
  assign wake_hit  = sense_over && (cfg_r[B_RHI] || cfg_r[B_RLO]); // [RQ22]
  assign idle_exit = avg_current > $signed(idle_r[15:0]) || wake_hit;
  assign low_v     = cell_voltage < volt_r[31:16];
  assign dorm_ok   = !cfg_r[B_SWIRE] && ocv_valid && abs_cur < idle_r[31:16]; // [RQ21]
  assign dorm_wake = state_r == ST_DORMANT && bus_activity && bus_addr_match; // [RQ18]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ST_NORMAL;
      wait_cnt_r    <= 16'h0;
      autocal_start <= 1'b0;
      by_low_v_r    <= 1'b0;
    end else begin
      autocal_start <= 1'b0;
      unique case (state_r)
        ST_NORMAL: begin
          if (dorm_ok && (low_v || cfg_r[B_DREQ])) begin
            state_r    <= ST_DORMANT; // [RQ17]
            by_low_v_r <= low_v;
          end else if (cfg_r[B_LIDLE] && avg_current < $signed(idle_r[15:0])) begin
            state_r       <= ST_CAL; // [RQ11]
            autocal_start <= 1'b1;
          end
        end
        ST_CAL: begin
          if (idle_exit) state_r <= ST_NORMAL;
          else if (autocal_done) begin
            state_r    <= ST_LIGHT; // [RQ11]
            wait_cnt_r <= lvl_r[15:0];
          end
        end
        ST_LIGHT: begin
          if (idle_exit) state_r <= ST_NORMAL; // [RQ13]
          else if (lvl_r[15:0] != 16'h0 ? wait_cnt_r == 16'h0 : deep_idle_r)
            state_r <= ST_DEEP; // [RQ14]
          else if (meas_tick && wait_cnt_r != 16'h0) wait_cnt_r <= wait_cnt_r - 16'h1;
        end
        ST_DEEP: begin
          if (idle_exit || bus_activity) state_r <= ST_NORMAL; // [RQ15] [RQ16]
        end
        ST_DORMANT: begin
          if (dorm_wake) state_r <= ST_NORMAL; // [RQ18]
        end
        default: state_r <= ST_NORMAL;
      endcase
    end
  end

  // deep idle flag: host command sets, bus wake clears when wait is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) deep_idle_r <= 1'b0;
    else if (wr_en && paddr == A_CFG && pwdata[B_DIDLE]) deep_idle_r <= 1'b1; // [RQ14]
    else if (state_r == ST_LIGHT && lvl_r[15:0] != 16'h0 && wait_cnt_r == 16'h0)
      deep_idle_r <= 1'b1;
    else if (state_r == ST_DEEP && bus_activity && lvl_r[15:0] == 16'h0)
      deep_idle_r <= 1'b0; // [RQ15]
  end

  // -----
  // outputs: measurement, bus hold, shutdown pin
  // -----
  logic idle_st;
  assign idle_st = state_r == ST_LIGHT || state_r == ST_DEEP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      measure_en          <= 1'b1;
      bus_hold_low        <= 1'b0;
      hold_cnt_r          <= 20'h0;
      shutdown_enable_pin <= 1'b0;
      power_state         <= ST_NORMAL;
    end else begin
      measure_en  <= state_r == ST_NORMAL; // [RQ10]
      power_state <= state_r;
      shutdown_enable_pin <= state_r == ST_DORMANT && by_low_v_r; // [RQ20]
      // hold ends when the core is ready or the 4 ms cap is reached
      if (bus_hold_low) begin
        hold_cnt_r <= hold_cnt_r + 20'h1;
        if (host_ready || hold_cnt_r >= 20'(STRETCH_CYCLES - 1))
          bus_hold_low <= 1'b0; // [RQ12]
      end else if (idle_st && bus_activity && !host_ready) begin
        bus_hold_low <= 1'b1; // [RQ12]
        hold_cnt_r   <= 20'h0;
      end
    end
  end

  assign stat_w = {22'h0, state_r, by_low_v_r, charge_inhibit_flag, full_charge_flag,
                   termination_alarm, charge_flag, discharge_overheat_flag,
                   charge_overheat_flag};

  // -----
  // checks
  // -----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  otd_disabled_a: assert property (dly_r[31:16] == 16'h0 |=> !discharge_overheat_flag) // [RQ4]
    else $error("discharge overheat set with zero delay");
  otc_disabled_a: assert property (dly_r[15:0] == 16'h0 |=> !charge_overheat_flag) // [RQ2]
    else $error("charge overheat set with zero delay");
  otc_timer_a: assert property (!chg_q |=> chg_cnt_r == 16'h0) // [RQ23]
    else $error("charge timer not restarted");
  otc_rise_a: assert property ($rose(charge_overheat_flag) |-> $past(chg_q)) // [RQ2]
    else $error("charge overheat without qualification");
  inh_set_a: assert property (9'(temp) < inh_lo |=> charge_inhibit_flag) // [RQ9]
    else $error("inhibit missing below low limit");
  term_chg_a: assert property (term |=> !charge_flag) // [RQ6]
    else $error("charge flag survived termination");
  wake_off_a: assert property (state_r == ST_LIGHT && !cfg_r[B_RHI] && !cfg_r[B_RLO] // [RQ22]
                               && avg_current <= $signed(idle_r[15:0])
                               |=> state_r != ST_NORMAL)
    else $error("wake active with ranges off");
  dorm_stay_a: assert property (state_r == ST_DORMANT && !(bus_activity && bus_addr_match)
                                |=> state_r == ST_DORMANT) // [RQ18]
    else $error("dormant left without own address");
  se_src_a: assert property (shutdown_enable_pin |-> $past(state_r) == ST_DORMANT
                             && by_low_v_r) // [RQ20]
    else $error("shutdown pin without low-voltage dormant");
  swire_a: assert property (cfg_r[B_SWIRE] && state_r == ST_NORMAL
                            |=> state_r != ST_DORMANT) // [RQ21]
    else $error("dormant entered on single-wire link");
  cal_first_a: assert property ($rose(state_r == ST_LIGHT) |-> $past(state_r) == ST_CAL) // [RQ11]
    else $error("light idle without calibration");
  hold_cap_a: assert property (bus_hold_low |-> hold_cnt_r < 20'(STRETCH_CYCLES)) // [RQ12]
    else $error("bus held beyond cap");

  cov_term_c:  cover property (term ##1 !charge_flag);
  cov_deep_c:  cover property (state_r == ST_LIGHT ##1 state_r == ST_DEEP);
  cov_dorm_c:  cover property (state_r == ST_DORMANT ##1 state_r == ST_NORMAL);
  cov_otc_c:   cover property ($rose(charge_overheat_flag));
endmodule

/* gfp_host_model.sv */
// Purpose: far-side model, host link and converter calibration responder
// Assumes: host_req is a one-cycle request from the bench, host_match its address match
// Notes:   a frame lasts four cycles plus however long the gauge stretches it
module gfp_host_model #(
  parameter int MAX_HOLD = 20
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic autocal_start,
  input  wire logic bus_hold_low,
  input  wire logic host_req,
  input  wire logic host_match,
  output logic      autocal_done,
  output logic      bus_activity,
  output logic      bus_addr_match,
  output logic      host_ready,
  output logic      stretch_err
);
  logic [2:0] cal_cnt;
  logic [2:0] frm_cnt;
  logic       match_r;
  int         hold_cnt;

  // -----
  // calibration responder
  // -----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt      <= 3'h0;
      autocal_done <= 1'b0;
    end else begin
      autocal_done <= (cal_cnt == 3'h1);
      if (autocal_start) begin
        cal_cnt <= 3'h3;
      end else if (cal_cnt != 3'h0) begin
        cal_cnt <= cal_cnt - 3'h1;
      end
    end
  end

  // -----
  // host frames
  // -----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_cnt     <= 3'h0;
      match_r     <= 1'b0;
      hold_cnt    <= 0;
      host_ready  <= 1'b0;
      stretch_err <= 1'b0;
    end else begin
      host_ready <= !host_req; // core busy in the first frame cycle
      if (host_req) begin
        frm_cnt <= 3'h4;
        match_r <= host_match;
      end else if (frm_cnt != 3'h0 && !bus_hold_low) begin
        frm_cnt <= frm_cnt - 3'h1; // frame waits out any stretch
      end
      hold_cnt <= bus_hold_low ? hold_cnt + 1 : 0;
      if (hold_cnt > MAX_HOLD) begin
        stretch_err <= 1'b1; // stretch longer than allowed
      end
    end
  end

  // released lines carry no match, so stale addresses cannot wake the gauge
  assign bus_activity   = (frm_cnt != 3'h0);
  assign bus_addr_match = bus_activity & match_r;
endmodule

/* gauge_flags_power_modes_tb_top.sv */
// Purpose: self-checking bench for flags and power-state sequencing
// Assumes: apb slave answers with one wait state, stretch limit shortened to 20 cycles
// Notes:   corners sit on every charge-inhibit band limit
module gauge_flags_power_modes_tb_top import gfp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd, seed;
  logic signed [7:0]  ext_temp, int_temp;
  logic signed [15:0] avg_current;
  logic [15:0]        cell_voltage, window_dcap;
  logic               meas_tick, window_tick, sense_over, ocv_valid, tca_hit, fc_hit;
  logic               autocal_done, bus_activity, bus_addr_match, host_ready, host_req;
  logic               host_match, stretch_err, rm_load_fcc, autocal_start, measure_en;
  logic               charge_overheat_flag, discharge_overheat_flag, charge_flag;
  logic               full_charge_flag, termination_alarm, charge_inhibit_flag;
  logic               bus_hold_low, shutdown_enable_pin;
  gfp_state_t         power_state;
  int                 errors, checks, fcc_cnt, cal_cnt, t, prev, hold_seen;
  int                 corner [8] = '{-1, 0, 5, 4, 46, 45, 40, 41};
  logic [31:0]        setup [8] = '{32'h2d3c2832, 32'h00052d00, 32'h00000003, 32'h00640064,
                                    32'h000a0014, 32'h00640032, 32'h0bb81068, 32'hffff0000};

  gfp_top #(.STRETCH_CYCLES(20)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_temp, .int_temp, .avg_current, .cell_voltage,
    .meas_tick, .window_tick, .window_dcap, .sense_over, .ocv_valid, .autocal_done, .tca_hit,
    .fc_hit, .bus_activity, .bus_addr_match, .host_ready, .charge_overheat_flag, .charge_flag,
    .discharge_overheat_flag, .full_charge_flag, .termination_alarm, .charge_inhibit_flag,
    .rm_load_fcc, .autocal_start, .measure_en, .bus_hold_low, .shutdown_enable_pin,
    .power_state);
  gfp_host_model #(.MAX_HOLD(20)) host (.pclk, .presetn, .autocal_start, .bus_hold_low,
    .host_req, .host_match, .autocal_done, .bus_activity, .bus_addr_match, .host_ready,
    .stretch_err);

  // -----
  // helpers
  // -----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      meas_tick <= 1'b1;
      @(posedge pclk);
      meas_tick <= 1'b0;
      @(posedge pclk);
    end
    cyc(2);
  endtask
  task automatic win(input logic [15:0] dc);
    window_dcap <= dc;
    window_tick <= 1'b1;
    @(posedge pclk);
    window_tick <= 1'b0;
    cyc(2);
  endtask
  task automatic wait_st(input gfp_state_t st);
    int n;
    n = 0;
    while (power_state !== st && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("power_state", st, power_state);
  endtask
  task automatic bus(input logic m);
    host_req   <= 1'b1;
    host_match <= m;
    @(posedge pclk);
    host_req   <= 1'b0;
    cyc(12);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // band edges inclusive: low + hys .. high - hys clears, outside limits sets
  function automatic int inh_exp(input int p, input int tv);
    if (tv < 0 || tv > 45) return 1;
    if (tv >= 5 && tv <= 40) return 0;
    return p;
  endfunction
  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // -----
  // clock, counters, watchdog
  // -----
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (rm_load_fcc === 1'b1) fcc_cnt++;
    if (autocal_start === 1'b1) cal_cnt++;
    if (bus_hold_low === 1'b1) hold_seen++;
  end
  initial begin
    cyc(20000);
    errors++;
    wrap_up();
  end

  // -----
  // main sequence
  // -----
  initial begin
    {presetn, psel, penable, pwrite, meas_tick, window_tick, sense_over} = '0;
    {ocv_valid, tca_hit, fc_hit, host_req, host_match, paddr, pwdata} = '0;
    {errors, checks, fcc_cnt, cal_cnt, hold_seen} = '0;
    ext_temp = 8'sd25;
    int_temp = 8'sd20;
    avg_current = 16'sd30;
    cell_voltage = 16'h1036;
    window_dcap = 16'h0000;
    seed = 32'h0000c25c;
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    chk("measure_en", 1, measure_en);
    chk("power_state", ST_NORMAL, power_state);
    apb(1'b0, A_CFG, 0);
    chk("cfg reset", 32'h01, rd & 32'hff);
    apb(1'b0, 8'h28, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(4 * (i + 1)), setup[i]);
    apb(1'b1, A_CFG, 32'h03);
    avg_current <= 16'sd150;
    cyc(2);
    chk("charge set", 1, charge_flag);
    avg_current <= 16'sd30;
    win(16'h0019);
    win(16'h001a);
    chk("term one window", 0, termination_alarm);
    chk("full one window", 0, full_charge_flag);
    win(16'h001a);
    chk("term alarm", 1, termination_alarm);
    chk("full flag", 1, full_charge_flag);
    chk("charge flag", 0, charge_flag);
    chk("capacity sync", 1, fcc_cnt);
    ext_temp <= 8'sd55;
    avg_current <= 16'sd150;
    tk(2);
    avg_current <= 16'sd50;
    tk(1);
    avg_current <= 16'sd150;
    tk(2);
    chk("chg ovh restart", 0, charge_overheat_flag);
    tk(1);
    chk("chg ovh set", 1, charge_overheat_flag);
    ext_temp <= 8'sd41;
    cyc(3);
    chk("chg ovh above rec", 1, charge_overheat_flag);
    ext_temp <= 8'sd40;
    cyc(3);
    chk("chg ovh recovered", 0, charge_overheat_flag);
    apb(1'b1, A_CFG, 32'h02);
    ext_temp <= 8'sd55;
    tk(4);
    chk("internal source cold", 0, charge_overheat_flag);
    int_temp <= 8'sd55;
    tk(3);
    chk("internal source hot", 1, charge_overheat_flag);
    int_temp <= 8'sd20;
    apb(1'b1, A_CFG, 32'h03);
    ext_temp <= 8'sd70;
    avg_current <= -16'sd150;
    tk(5);
    chk("dsg ovh disabled", 0, discharge_overheat_flag);
    ext_temp <= 8'sd20;
    apb(1'b1, A_DLY, 32'h00020003);
    ext_temp <= 8'sd70;
    tk(1);
    chk("dsg ovh early", 0, discharge_overheat_flag);
    tk(1);
    chk("dsg ovh set", 1, discharge_overheat_flag);
    ext_temp <= 8'sd45;
    cyc(3);
    chk("dsg ovh recovered", 0, discharge_overheat_flag);
    ext_temp <= 8'sd20;
    cyc(3);
    prev = 0;
    chk("inhibit start", 0, charge_inhibit_flag);
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      t = (i < 8) ? corner[i] : int'(seed % 32'd90) - 20;
      ext_temp <= 8'(t);
      int_temp <= seed[15:8];
      cyc(3);
      prev = inh_exp(prev, t);
      chk("charge inhibit", prev, charge_inhibit_flag);
    end
    ext_temp <= 8'sd25;
    int_temp <= 8'sd20;
    avg_current <= 16'sd10;
    cal_cnt = 0;
    apb(1'b1, A_CFG, 32'h05);
    wait_st(ST_LIGHT);
    chk("autocal pulses", 1, cal_cnt);
    chk("measure_en idle", 0, measure_en);
    sense_over <= 1'b1;
    cyc(5);
    chk("wake masked", ST_LIGHT, power_state);
    sense_over <= 1'b0;
    apb(1'b1, A_CFG, 32'h0d);
    sense_over <= 1'b1;
    wait_st(ST_NORMAL);
    sense_over <= 1'b0;
    wait_st(ST_LIGHT);
    apb(1'b1, A_CFG, 32'h8d);
    wait_st(ST_DEEP);
    bus(1'b0);
    wait_st(ST_LIGHT);
    cyc(20);
    chk("no deep reentry", ST_LIGHT, power_state);
    apb(1'b0, A_CFG, 0);
    chk("deep flag cleared", 0, rd[B_DIDLE]);
    apb(1'b1, A_LVL, 32'hffff0002);
    avg_current <= 16'sd30;
    wait_st(ST_NORMAL);
    avg_current <= 16'sd10;
    wait_st(ST_LIGHT);
    tk(2);
    wait_st(ST_DEEP);
    bus(1'b0);
    apb(1'b0, A_CFG, 0);
    chk("deep flag kept", 1, rd[B_DIDLE]);
    tk(2);
    wait_st(ST_DEEP);
    avg_current <= 16'sd30;
    wait_st(ST_NORMAL);
    apb(1'b1, A_CFG, 32'h41);
    avg_current <= 16'sd5;
    cyc(10);
    chk("dormant needs ocv", ST_NORMAL, power_state);
    ocv_valid <= 1'b1;
    wait_st(ST_DORMANT);
    chk("shutdown on request", 0, shutdown_enable_pin);
    bus(1'b0);
    chk("foreign traffic", ST_DORMANT, power_state);
    bus(1'b1);
    wait_st(ST_NORMAL);
    apb(1'b0, A_CFG, 0);
    chk("dormant request cleared", 0, rd[B_DREQ]);
    cell_voltage <= 16'h0b54;
    wait_st(ST_DORMANT);
    chk("shutdown on low volt", 1, shutdown_enable_pin);
    cell_voltage <= 16'h1036;
    bus(1'b1);
    wait_st(ST_NORMAL);
    apb(1'b1, A_CFG, 32'h61);
    cyc(10);
    chk("single wire blocks", ST_NORMAL, power_state);
    chk("stretch bound", 0, stretch_err);
    chk("bus hold", 1, hold_seen > 0);
    tca_hit <= 1'b1;
    fc_hit <= 1'b1;
    apb(1'b1, A_LVL, 32'h00ff0002);
    cyc(2);
    chk("alarm level off", 0, termination_alarm);
    chk("full level", 1, full_charge_flag);
    wrap_up();
  end
endmodule
